// >>> tw_bus_master.sv
// Behavioural two-wire bus master driving open-drain enables
`timescale 1ns/10ps
module tw_bus_master (
   // Wire levels
   input wire logic scl_i,
   input wire logic sda_i,
   // Pull-down enables
   output logic scl_oe,
   output logic sda_oe
   );
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
   end
   task start;
      sda_oe = 1'b1;
      #100 scl_oe = 1'b1;
   endtask
   task bit_io(input logic b, output logic r);
      sda_oe = !b;
      #50 scl_oe = 1'b0;
      // Slave may stretch the low phase
      wait (scl_i);
      r = sda_i;
      #100 scl_oe = 1'b1;
      #50;
   endtask
   task send(input logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
   endtask
   task stop;
      sda_oe = 1'b1;
      #50 scl_oe = 1'b0;
      wait (scl_i);
      #100 sda_oe = 1'b0;
      #100;
   endtask
endmodule

// >>> tw_pkg.sv
// Package of register map and constants for the two-wire slave flag block
package tw_pkg;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_CMD = 8'h08;
   localparam logic [7:0] OFF_DATA = 8'h0C;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFF_IRQ_CLR = 8'h14;
   localparam logic [7:0] OFF_IRQ_EN = 8'h18;
   localparam logic [7:0] OFF_ADDR = 8'h1C;
   // Control fields
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_TMO_EN_BIT = 1;
   // Status fields (write 1 clears flags)
   localparam int ST_ADDRESS_STOP_IRQ_FLAG_BIT = 0;
   localparam int ST_DIF_BIT = 1;
   localparam int ST_COLL_BIT = 2;
   localparam int ST_HOLD_BIT = 3;
   localparam int ST_IDLE_BIT = 4;
   localparam int ST_STOP_BIT = 5;
   localparam int ST_DIR_BIT = 6;
   localparam int ST_SCL_BIT = 7;
   // Slave response command field
   localparam logic [1:0] CMD_RESPONSE = 2'h3;
   localparam int CMD_ACKN_BIT = 2;
   // Interrupt event bits
   localparam int EV_ADDR = 0;
   localparam int EV_DATA = 1;
   localparam int EV_STOP = 2;
   localparam int EV_TMO = 3;
   localparam int EV_W = 4;
   // Reset values
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam logic [6:0] ADDR_RST = 7'h00;
   // Bus timeout: high level time on both lines
   localparam int CLK_HZ = 40000000;
   localparam int TMO_US = 50;
   localparam int TMO_CYC = (TMO_US * (CLK_HZ / 1000000));
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
   typedef enum {ST_IDLE, ST_ADDR, ST_HOLD, ST_DATA, ST_ACK} tw_state_t;
endpackage

// >>> tw_slave.sv
// Two-wire slave with flag handling, AXI4-Lite register access
// Behaviour
// R1: Collision flag clears on START and stays on a repeated START.
// R2: Software clears the collision flag itself after address interrupt.
// R3: Address/stop flag sets when a matching address is received.
// R4: Clearing the address/stop flag releases clock hold and SCL.
// R5: A clear in the same cycle as an address set keeps SCL held.
// R6: Software clears the flag only when idle or while SCL is low.
// R7: Timeout in the same cycle as START drops that transaction.
// R8: Data flag clears one cycle after the response command.
// R9: Software waits one cycle after the command before testing data flag.
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
module tw_slave
   import tw_pkg::*;
   (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // AXI4-Lite slave
   input wire logic [7:0] S_AWADDR,
   input wire logic S_AWVALID,
   output logic S_AWREADY,
   input wire logic [31:0] S_WDATA,
   input wire logic [3:0] S_WSTRB,
   input wire logic S_WVALID,
   output logic S_WREADY,
   output logic [1:0] S_BRESP,
   output logic S_BVALID,
   input wire logic S_BREADY,
   input wire logic [7:0] S_ARADDR,
   input wire logic S_ARVALID,
   output logic S_ARREADY,
   output logic [31:0] S_RDATA,
   output logic [1:0] S_RRESP,
   output logic S_RVALID,
   input wire logic S_RREADY,
   // Two-wire pins
   input wire logic SCL_I,
   output logic SCL_O,
   output logic SCL_OE,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE,
   // Interrupt
   output logic IRQ
   );

   logic scl_m, scl_s, sda_m, sda_s, scl_d, sda_d;
   logic [1:0] ctrl_ff;
   logic [6:0] addr_ff;
   logic address_stop_irq_flag_ff, dif_ff, coll_ff, hold_ff, stop_ff, dir_ff, busy_ff;
   logic [3:0] irq_st_ff, irq_en_ff;
   logic dif_clr_ff, ack_ff;
   logic [7:0] shift_ff, txd_ff, rxd_ff;
   logic [3:0] bit_ff;
   logic [15:0] tmo_ff;
   logic sda_oe_ff;
   tw_state_t st_ff;
   logic [7:0] aw_ff;
   logic aw_v_ff, w_v_ff;
   logic [31:0] wd_ff;
   logic [3:0] ws_ff;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and bus conditions
   always_ff @(posedge CLK) begin
      scl_m <= SCL_I;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= SDA_I;
      sda_s <= sda_m;
      sda_d <= sda_s;
   end

   logic scl_rise, scl_fall, start_det, stop_det, tmo_hit, en;
   assign en = ctrl_ff[CTRL_EN_BIT];
   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   assign start_det = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_det = scl_s & scl_d & ~sda_d & sda_s;
   assign tmo_hit = ctrl_ff[CTRL_TMO_EN_BIT] && busy_ff &&
                    (tmo_ff == 16'(TMO_CYC - 1));

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite handshakes and write path
   logic wr_go, rd_go;
   assign S_AWREADY = ~aw_v_ff & ~S_BVALID;
   assign S_WREADY = ~w_v_ff & ~S_BVALID;
   assign wr_go = aw_v_ff & w_v_ff & ~S_BVALID;
   assign S_ARREADY = ~S_RVALID;
   assign rd_go = S_ARVALID & S_ARREADY;

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         aw_v_ff <= 1'b0;
         w_v_ff <= 1'b0;
         aw_ff <= 8'h00;
         wd_ff <= 32'h00000000;
         ws_ff <= 4'h0;
         S_BVALID <= 1'b0;
         S_BRESP <= AXI_OKAY;
      end else begin
         if (S_AWVALID && S_AWREADY) begin
            aw_v_ff <= 1'b1;
            aw_ff <= S_AWADDR;
         end
         if (S_WVALID && S_WREADY) begin
            w_v_ff <= 1'b1;
            wd_ff <= S_WDATA;
            ws_ff <= S_WSTRB;
         end
         if (wr_go) begin
            aw_v_ff <= 1'b0;
            w_v_ff <= 1'b0;
            S_BVALID <= 1'b1;
            S_BRESP <= (aw_ff[7:2] <= OFF_ADDR[7:2]) ? AXI_OKAY : AXI_SLVERR;
         end else if (S_BREADY) begin
            S_BVALID <= 1'b0;
         end
      end
   end

   logic wb0;
   logic w_ctrl, w_stat, w_cmd, w_data, w_iclr, w_ien, w_addr;
   assign wb0 = wr_go & ws_ff[0];
   assign w_ctrl = wb0 && aw_ff[7:2] == OFF_CTRL[7:2];
   assign w_stat = wb0 && aw_ff[7:2] == OFF_STATUS[7:2];
   assign w_cmd = wb0 && aw_ff[7:2] == OFF_CMD[7:2];
   assign w_data = wb0 && aw_ff[7:2] == OFF_DATA[7:2];
   assign w_iclr = wb0 && aw_ff[7:2] == OFF_IRQ_CLR[7:2];
   assign w_ien = wb0 && aw_ff[7:2] == OFF_IRQ_EN[7:2];
   assign w_addr = wb0 && aw_ff[7:2] == OFF_ADDR[7:2];

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         ctrl_ff <= CTRL_RST;
         addr_ff <= ADDR_RST;
         irq_en_ff <= 4'h0;
         txd_ff <= 8'h00;
      end else begin
         if (w_ctrl) ctrl_ff <= wd_ff[1:0];
         if (w_addr) addr_ff <= wd_ff[6:0];
         if (w_ien) irq_en_ff <= wd_ff[3:0];
         if (w_data) txd_ff <= wd_ff[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Slave bus engine
   logic addr_ev, data_ev, address_stop_irq_flag_clr, resp_cmd;
   logic clr_race;
   assign address_stop_irq_flag_clr = w_stat & wd_ff[ST_ADDRESS_STOP_IRQ_FLAG_BIT];
   assign resp_cmd = w_cmd && wd_ff[1:0] == CMD_RESPONSE;
   // Address match at the eighth bit's falling edge
   assign addr_ev = en && st_ff == ST_ADDR && scl_fall && bit_ff == 4'h8 &&
                    shift_ff[7:1] == addr_ff;
   assign data_ev = en && st_ff == ST_DATA && scl_fall && bit_ff == 4'h8;
   assign clr_race = address_stop_irq_flag_clr & addr_ev;

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         st_ff <= ST_IDLE;
         bit_ff <= 4'h0;
         shift_ff <= 8'h00;
         rxd_ff <= 8'h00;
         dir_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
         ack_ff <= 1'b0;
      end else if (!en || stop_det || tmo_hit) begin
         // Timeout beside START drops the new transaction
         st_ff <= ST_IDLE; // see R7
         sda_oe_ff <= 1'b0;
      end else if (start_det) begin
         st_ff <= ST_ADDR;
         bit_ff <= 4'h0;
         sda_oe_ff <= 1'b0;
      end else begin
         case (st_ff)
            ST_IDLE: begin
            end
            ST_ADDR, ST_DATA: begin
               if (scl_rise && bit_ff != 4'h8) begin
                  shift_ff <= {shift_ff[6:0], sda_s};
                  bit_ff <= bit_ff + 4'h1;
               end
               if (scl_fall && dir_ff && st_ff == ST_DATA && bit_ff != 4'h8)
                  sda_oe_ff <= ~shift_ff[7];
               if (addr_ev) begin
                  dir_ff <= shift_ff[0];
                  st_ff <= ST_HOLD;
               end else if (st_ff == ST_ADDR && scl_fall && bit_ff == 4'h8) begin
                  st_ff <= ST_IDLE;
               end else if (data_ev) begin
                  if (!dir_ff) rxd_ff <= shift_ff;
                  st_ff <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (resp_cmd) begin
                  ack_ff <= ~wd_ff[CMD_ACKN_BIT];
                  sda_oe_ff <= ~dir_ff & ~wd_ff[CMD_ACKN_BIT];
                  st_ff <= ST_ACK;
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  bit_ff <= 4'h0;
                  shift_ff <= txd_ff;
                  sda_oe_ff <= dir_ff & ~txd_ff[7];
                  st_ff <= ack_ff ? ST_DATA : ST_IDLE;
               end
            end
            default: st_ff <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Flags
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         address_stop_irq_flag_ff <= 1'b0;
         hold_ff <= 1'b0;
         stop_ff <= 1'b0;
      end else begin
         if (addr_ev) begin
            address_stop_irq_flag_ff <= 1'b1; // see R3
            hold_ff <= 1'b1;
         end else if (stop_det && busy_ff) begin
            address_stop_irq_flag_ff <= 1'b1;
            stop_ff <= 1'b1;
         end else if (address_stop_irq_flag_clr) begin
            address_stop_irq_flag_ff <= 1'b0;
            stop_ff <= 1'b0;
         end
         // Hold released by clear, kept on the race cycle
         if (address_stop_irq_flag_clr && !clr_race) hold_ff <= 1'b0; // see R4, R5
         else if (data_ev) hold_ff <= 1'b1;
         else if (resp_cmd && st_ff == ST_HOLD && !address_stop_irq_flag_ff) hold_ff <= 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         dif_ff <= 1'b0;
         dif_clr_ff <= 1'b0;
      end else begin
         // Delayed clear after response command
         dif_clr_ff <= resp_cmd; // see R8
         if (data_ev) dif_ff <= 1'b1;
         else if (dif_clr_ff || (w_stat && wd_ff[ST_DIF_BIT])) dif_ff <= 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         coll_ff <= 1'b0;
         busy_ff <= 1'b0;
         tmo_ff <= 16'h0000;
      end else begin
         // Set on lost arbitration of driven data
         if (sda_oe_ff == 1'b0 && dir_ff && st_ff == ST_DATA && scl_rise &&
             !sda_s && shift_ff[7])
            coll_ff <= 1'b1;
         else if (start_det && !busy_ff)
            coll_ff <= 1'b0; // see R1, R2
         else if (w_stat && wd_ff[ST_COLL_BIT])
            coll_ff <= 1'b0;
         if (start_det) busy_ff <= 1'b1;
         else if (stop_det || tmo_hit) busy_ff <= 1'b0;
         if (!busy_ff || !(scl_s && sda_s)) tmo_ff <= 16'h0000;
         else tmo_ff <= tmo_ff + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupts and read path
   logic [3:0] ev;
   assign ev = {tmo_hit, stop_det & busy_ff, data_ev, addr_ev};
   always_ff @(posedge CLK) begin
      if (!RESET_N) irq_st_ff <= 4'h0;
      else irq_st_ff <= ev | (irq_st_ff & ~(w_iclr ? wd_ff[3:0] : 4'h0));
   end
   assign IRQ = |(irq_st_ff & irq_en_ff);

   logic [31:0] rd_val;
   always_comb begin
      rd_val = 32'h00000000;
      case (S_ARADDR[7:2])
         OFF_CTRL[7:2]: rd_val[1:0] = ctrl_ff;
         OFF_STATUS[7:2]: rd_val[7:0] = {scl_s, dir_ff, stop_ff, ~busy_ff,
                                         hold_ff, coll_ff, dif_ff, address_stop_irq_flag_ff};
         OFF_DATA[7:2]: rd_val[7:0] = rxd_ff;
         OFF_IRQ_STAT[7:2]: rd_val[3:0] = irq_st_ff;
         OFF_IRQ_EN[7:2]: rd_val[3:0] = irq_en_ff;
         OFF_ADDR[7:2]: rd_val[6:0] = addr_ff;
         default: rd_val = 32'h00000000;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         S_RVALID <= 1'b0;
         S_RDATA <= 32'h00000000;
         S_RRESP <= AXI_OKAY;
      end else if (rd_go) begin
         S_RVALID <= 1'b1;
         S_RDATA <= rd_val;
         S_RRESP <= (S_ARADDR[7:2] <= OFF_ADDR[7:2]) ? AXI_OKAY : AXI_SLVERR;
      end else if (S_RREADY) begin
         S_RVALID <= 1'b0;
      end
   end

   assign SCL_O = 1'b0;
   assign SCL_OE = hold_ff & ~scl_s;
   assign SDA_O = 1'b0;
   assign SDA_OE = sda_oe_ff;
endmodule

// >>> tw_slave_properties.sv
// Checker of bus handshake and pin behaviour for the two-wire slave
`timescale 1ns/10ps
module tw_slave_properties
   import tw_pkg::*;
   (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // Register bus
   input wire logic S_AWVALID,
   input wire logic S_AWREADY,
   input wire logic S_WVALID,
   input wire logic S_WREADY,
   input wire logic S_BVALID,
   input wire logic S_BREADY,
   input wire logic [7:0] S_ARADDR,
   input wire logic S_ARVALID,
   input wire logic S_ARREADY,
   input wire logic [31:0] S_RDATA,
   input wire logic [1:0] S_RRESP,
   input wire logic S_RVALID,
   input wire logic S_RREADY,
   // Pin drive values
   input wire logic SCL_O,
   input wire logic SDA_O
   );
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   ////////////////////////////////////////////////////////////////////////
   sequence wr_take;
      S_AWVALID && S_AWREADY && S_WVALID && S_WREADY;
   endsequence
   sequence rd_take;
      S_ARVALID && S_ARREADY;
   endsequence
   a_bresp_hold: assert property (S_BVALID && !S_BREADY |=> S_BVALID)
      else $error("write response dropped early");
   a_rdata_hold: assert property (S_RVALID && !S_RREADY |=>
      S_RVALID && $stable(S_RDATA)) else $error("read data not held");
   a_write_busy: assert property (S_BVALID |-> !S_AWREADY && !S_WREADY)
      else $error("write taken while response pending");
   a_read_busy: assert property (S_RVALID |-> !S_ARREADY)
      else $error("read taken while data pending");
   a_write_answer: assert property (wr_take |-> ##[1:2] S_BVALID)
      else $error("write response late");
   a_read_answer: assert property (rd_take |=> S_RVALID)
      else $error("read data late");
   a_unmapped_read: assert property (rd_take and S_ARADDR > OFF_ADDR |=>
      S_RRESP == AXI_SLVERR && S_RDATA == 32'h0)
      else $error("unmapped read not refused");
   a_pins_low: assert property (SCL_O == 1'b0 && SDA_O == 1'b0)
      else $error("pin drive value not low");
endmodule
bind tw_slave tw_slave_properties u_props (.*);

// >>> tw_slave_tb.sv
// Testbench of the two-wire slave flag block
`timescale 1ns/10ps
module tw_slave_tb;
   import tw_pkg::*;
   logic CLK = 1'b0;
   logic RESET_N = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rv;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, irq, ak;
   logic [1:0] rresp, bresp, rr;
   logic [6:0] adr;
   logic [7:0] dat;
   wire m_scl, m_sda;
   wire scl = !(scl_oe | m_scl);
   wire sda = !(sda_oe | m_sda);
   int n_fail = 0, compares = 0, exp_irq = 0;
   always #12.5 CLK = !CLK;
   tw_slave u_tw_slave (.CLK(CLK), .RESET_N(RESET_N), .S_AWADDR(awaddr),
      .S_AWVALID(awvalid), .S_AWREADY(awready), .S_WDATA(wdata),
      .S_WSTRB(4'hF), .S_WVALID(wvalid), .S_WREADY(wready),
      .S_BRESP(bresp), .S_BVALID(bvalid), .S_BREADY(bready),
      .S_ARADDR(araddr), .S_ARVALID(arvalid), .S_ARREADY(arready),
      .S_RDATA(rdata), .S_RRESP(rresp), .S_RVALID(rvalid),
      .S_RREADY(rready), .SCL_I(scl), .SCL_O(), .SCL_OE(scl_oe),
      .SDA_I(sda), .SDA_O(), .SDA_OE(sda_oe), .IRQ(irq));
   tw_bus_master u_m (.scl_i(scl), .sda_i(sda), .scl_oe(m_scl),
      .sda_oe(m_sda));
   ////////////////////////////////////////////////////////////////////////
   task complete_run;
      $display("n_fail %0d compares %0d", n_fail, compares);
      if (n_fail == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic ha, hw, dn;
      @(posedge CLK);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge CLK);
         ha = awvalid && awready;
         hw = wvalid && wready;
         dn = bvalid;
         rr = bresp;
         @(posedge CLK);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         if (dn) bready <= 1'b0;
      end while (!dn);
   endtask
   task rd(input logic [7:0] a);
      logic ha, dn;
      @(posedge CLK);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge CLK);
         ha = arvalid && arready;
         dn = rvalid;
         rv = rdata;
         rr = rresp;
         @(posedge CLK);
         if (ha) arvalid <= 1'b0;
         if (dn) rready <= 1'b0;
      end while (!dn);
   endtask
   task ci(input logic e);
      @(negedge CLK);
      chk({31'h0, irq}, {31'h0, e});
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      n_fail++;
      complete_run;
   end
   initial begin
      rv = $urandom(60636);
      adr = 7'($urandom_range(8, 119));
      dat = 8'($urandom);
      repeat (2) @(posedge CLK);
      RESET_N <= 1'b1;
      rd(OFF_CTRL);
      chk(rv, 32'h0);
      rd(8'h20);
      chk({30'h0, rr}, {30'h0, AXI_SLVERR});
      wr(OFF_ADDR, {25'h0, adr});
      wr(OFF_CTRL, 32'h3);
      chk({30'h0, rr}, {30'h0, AXI_OKAY});
      wr(8'h20, 32'h0);
      chk({30'h0, rr}, {30'h0, AXI_SLVERR});
      wr(OFF_IRQ_EN, 32'hF);
      u_m.start();
      u_m.send({adr, 1'b0});
      wait (irq === 1'b1);
      rd(OFF_STATUS);
      chk({31'h0, rv[ST_ADDRESS_STOP_IRQ_FLAG_BIT]}, 32'h1);
      chk({31'h0, rv[ST_HOLD_BIT]}, 32'h1);
      wr(OFF_CMD, {30'h0, CMD_RESPONSE});
      wr(OFF_STATUS, 32'h5);
      rd(OFF_STATUS);
      chk({30'h0, rv[ST_HOLD_BIT], rv[ST_ADDRESS_STOP_IRQ_FLAG_BIT]}, 32'h0);
      u_m.bit_io(1'b1, ak);
      chk({31'h0, ak}, 32'h0);
      u_m.send(dat);
      // Synchroniser latency
      repeat (8) @(posedge CLK);
      rd(OFF_STATUS);
      chk({31'h0, rv[ST_DIF_BIT]}, 32'h1);
      wr(OFF_CMD, {30'h0, CMD_RESPONSE});
      rd(OFF_STATUS);
      rd(OFF_STATUS);
      chk({31'h0, rv[ST_DIF_BIT]}, 32'h0);
      rd(OFF_DATA);
      chk(rv & 32'hFF, {24'h0, dat});
      u_m.bit_io(1'b1, ak);
      u_m.stop();
      repeat (8) @(posedge CLK);
      exp_irq = (1 << EV_ADDR) | (1 << EV_DATA) | (1 << EV_STOP);
      rd(OFF_IRQ_STAT);
      chk(rv, 32'(exp_irq));
      wr(OFF_IRQ_EN, 32'h0);
      ci(1'b0);
      wr(OFF_IRQ_EN, 32'hF);
      ci(1'b1);
      wr(OFF_IRQ_CLR, 32'hF);
      ci(1'b0);
      rd(OFF_IRQ_STAT);
      chk(rv, 32'h0);
      complete_run;
   end
endmodule
